// ==== core/scf_fan_ctrl.sv ====
`timescale 1ns/10ps
// How it works
// - Tach toggles on each sensor edge while running
// - South lock: b low, a pulsed on/off
// - North lock: a low, b pulsed on/off
// - Lock-detect on-time is 420 ms
// - Off-time is ten times on-time
// - PWM low past 65 ms: outputs low
// - Standby entry clears pending off-time
// - Standby releases tach open-drain switch
// - First PWM high starts fresh on-time
// - Wait 100 us for sensor settling
// - Overvoltage switches drive off, enters standby
// - Coil drive gated by PWM input
// - Coil current ramped softly at commutation
// - Soft transition lasts 200 us
module scf_fan_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pole_south,
  input wire logic pwm_in,
  input wire logic overvoltage_threshold,
  output logic coil_out_a,
  output logic coil_out_b,
  output logic tach_output_o,
  output logic tach_output_oe
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Every pin is asynchronous to clk; only the second flop is read
  // Two flops trade two cycles of latency for metastability margin
  wire [2:0] pin_raw = {overvoltage_threshold, pwm_in, pole_south};
  wire [2:0] pin_sync;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      logic s1_ff;
      logic s2_ff;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_ff <= 1'b0;
          s2_ff <= 1'b0;
        end else begin
          s1_ff <= pin_raw[gi];
          s2_ff <= s1_ff;
        end
      end
      assign pin_sync[gi] = s2_ff;
    end
  endgenerate
  wire pole = pin_sync[0];
  wire pwm = pin_sync[1];
  wire ov = pin_sync[2];

  // ----------------------------------------
  // Sensor edge and state
  // ----------------------------------------
  scf_pkg::scf_state_type state_ff;
  scf_pkg::scf_state_type nxt_state;
  // One down-counter serves settle, on-time and off-time in turn
  logic [31:0] tmr_ff;
  logic [31:0] nxt_tmr;
  logic [31:0] low_ff;
  logic pole_ff;
  logic lock_pole_ff;

  // Any sensor change is motion, whichever pole it reaches
  wire pole_edge = pole != pole_ff;
  wire low_long = low_ff >= scf_pkg::STBY_CYC;
  wire tmr_done = tmr_ff == 32'h0;
  wire [31:0] tmr_dec = tmr_done ? 32'h0 : tmr_ff - 32'h1;

  always_comb begin
    nxt_state = state_ff;
    nxt_tmr = tmr_dec;
    // Overvoltage and a long PWM low override every state
    if (ov || low_long) begin
      nxt_state = scf_pkg::SCF_STBY;
      nxt_tmr = 32'h0;  // Any off-time is dropped
    end else begin
      case (state_ff)
        scf_pkg::SCF_STBY: begin
          // Off-time was cleared on entry, so restart is immediate
          if (pwm) begin
            nxt_state = scf_pkg::SCF_SETTLE;
            nxt_tmr = scf_pkg::SETTLE_CYC;
          end
        end
        scf_pkg::SCF_SETTLE: begin
          // Sensor output is not trusted until the settle count ends
          if (tmr_done) begin
            nxt_state = scf_pkg::SCF_RUN;
            nxt_tmr = scf_pkg::ON_CYC;  // Fresh on-time, no off-time
          end
        end
        scf_pkg::SCF_RUN: begin
          if (pole_edge) begin
            nxt_tmr = scf_pkg::ON_CYC;
          end else if (tmr_done) begin
            nxt_state = scf_pkg::SCF_LOCK_OFF;
            nxt_tmr = scf_pkg::OFF_CYC;
          end
        end
        scf_pkg::SCF_LOCK_OFF: begin
          // Coils stay low for the whole off-time
          if (tmr_done) begin
            nxt_state = scf_pkg::SCF_LOCK_ON;  // Retry drive
            nxt_tmr = scf_pkg::ON_CYC;
          end
        end
        scf_pkg::SCF_LOCK_ON: begin
          if (pole_edge) begin
            nxt_state = scf_pkg::SCF_RUN;  // Spinning again
            nxt_tmr = scf_pkg::ON_CYC;
          end else if (tmr_done) begin
            nxt_state = scf_pkg::SCF_LOCK_OFF;
            nxt_tmr = scf_pkg::OFF_CYC;
          end
        end
        default: begin
          nxt_state = scf_pkg::SCF_STBY;
          nxt_tmr = 32'h0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= scf_pkg::SCF_STBY;
      tmr_ff <= 32'h0;
      low_ff <= 32'h0;
      pole_ff <= 1'b0;
      lock_pole_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      tmr_ff <= nxt_tmr;
      // Saturates so a stuck-low input cannot wrap back out of standby
      low_ff <= pwm ? 32'h0 : (low_long ? low_ff : low_ff + 32'h1);
      pole_ff <= pole;
      // Pole frozen at lock: only the coil facing the stalled rotor pulses
      if (nxt_state == scf_pkg::SCF_LOCK_OFF && state_ff != scf_pkg::SCF_LOCK_OFF) begin
        lock_pole_ff <= pole;
      end
    end
  end

  // ----------------------------------------
  // Coil drive
  // ----------------------------------------
  // Both coils use the same on-decision, so it is decoded in one place
  function automatic logic coil_on(
    input logic pwm_hi,
    input logic run_on,
    input logic soft_on,
    input logic lock_hit
  );
    coil_on = pwm_hi && ((run_on && soft_on) || lock_hit);
  endfunction

  logic soft_a;
  logic soft_b;
  // Soft ramp follows pole: south drives a high, b low
  scf_soft_ramp #(.RAMP_CYC(scf_pkg::SOFT_CYC)) u_ramp (
    .clk(clk),
    .rst_n(rst_n),
    .dir(!pole),
    .drive_a(soft_a),
    .drive_b(soft_b)
  );
  wire run = state_ff == scf_pkg::SCF_RUN;
  wire lock_on = state_ff == scf_pkg::SCF_LOCK_ON;
  // Locked rotor: only the pole-matched output pulses, the other stays low
  wire nxt_a = coil_on(pwm, run, soft_a, lock_on && lock_pole_ff);
  wire nxt_b = coil_on(pwm, run, soft_b, lock_on && !lock_pole_ff);
  // PWM gates after the ramp, so chopping never restarts a ramp
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      coil_out_a <= 1'b0;
      coil_out_b <= 1'b0;
    end else begin
      coil_out_a <= nxt_a;
      coil_out_b <= nxt_b;
    end
  end

  // ----------------------------------------
  // Tachometer
  // ----------------------------------------
  logic tach_ff;
  logic tach_oe_ff;
  logic tach_data_ff;
  logic pole_run_ff;
  wire tach_flip = run && pole != pole_run_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tach_ff <= 1'b0;
      tach_oe_ff <= 1'b0;
      tach_data_ff <= 1'b0;
      pole_run_ff <= 1'b0;
    end else begin
      pole_run_ff <= pole;
      // Tach follows commutation (sensor edges), not PWM chopping of coil a
      if (tach_flip) begin
        tach_ff <= !tach_ff;
      end
      // Pull-down whenever the next state is not standby and tach is low; standby releases the pin
      tach_oe_ff <= (nxt_state != scf_pkg::SCF_STBY) && !tach_ff;
      // Open-drain pin: the data bit stays low, only the enable moves
      tach_data_ff <= 1'b0;
    end
  end
  assign tach_output_o = tach_data_ff;
  assign tach_output_oe = tach_oe_ff;
endmodule // scf_fan_ctrl

// ==== core/scf_pkg.sv ====
package scf_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned T_ON_MS = 420;
  localparam int unsigned OFF_RATIO = 10;
  localparam int unsigned T_STBY_MS = 65;
  localparam int unsigned T_SETTLE_US = 100;
  localparam int unsigned T_SOFT_US = 200;
  localparam int unsigned ON_CYC = (CLK_HZ / 1000) * T_ON_MS;
  localparam int unsigned OFF_CYC = ON_CYC * OFF_RATIO;
  localparam int unsigned STBY_CYC = (CLK_HZ / 1000) * T_STBY_MS;
  localparam int unsigned SETTLE_CYC = (CLK_HZ / 1000000) * T_SETTLE_US;
  localparam int unsigned SOFT_CYC = (CLK_HZ / 1000000) * T_SOFT_US;
  localparam int unsigned SOFT_PWM_W = 8;
  localparam int unsigned CNT_W = 32;

  // ----------------------------------------
  // States
  // ----------------------------------------
  typedef enum logic [4:0] {
    SCF_STBY = 5'h01,
    SCF_SETTLE = 5'h02,
    SCF_RUN = 5'h04,
    SCF_LOCK_ON = 5'h08,
    SCF_LOCK_OFF = 5'h10
  } scf_state_type;
endpackage

// ==== core/scf_soft_ramp.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// Soft direction change: duty ramps from old to new polarity
// ----------------------------------------
module scf_soft_ramp #(
  parameter int unsigned RAMP_CYC = 10000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic dir,
  output logic drive_a,
  output logic drive_b
);
  logic [31:0] ramp_ff;
  logic [31:0] nxt_ramp;
  logic [7:0] pwm_ff;
  logic dir_ff;
  logic new_dir_on;
  wire [39:0] scaled;
  wire ramping;
  assign ramping = ramp_ff != 32'h0;
  assign nxt_ramp = (dir != dir_ff) ? RAMP_CYC : (ramping ? ramp_ff - 32'h1 : 32'h0);
  // Linear ramp: new direction duty grows as the countdown falls
  assign scaled = {8'h00, (RAMP_CYC - ramp_ff)} * 40'h100 / RAMP_CYC;
  assign new_dir_on = !ramping || ({1'b0, pwm_ff} < scaled[8:0]);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ramp_ff <= 32'h0;
      pwm_ff <= 8'h00;
      // Matches dir while the synchronised pole is at its reset level (0), so reset starts no ramp
      dir_ff <= 1'b1;
    end else begin
      ramp_ff <= nxt_ramp;
      pwm_ff <= pwm_ff + 8'h01;
      dir_ff <= dir;
    end
  end
  // Direction in use this cycle
  wire cur = new_dir_on ? dir_ff : !dir_ff;
  assign drive_a = !cur;
  assign drive_b = cur;
endmodule // scf_soft_ramp

// ==== verification/scf_fan_monitor.sv ====
`timescale 1ns/10ps
module scf_fan_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pole_south,
  input wire logic pwm_in,
  input wire logic overvoltage_threshold,
  input wire logic coil_out_a,
  input wire logic coil_out_b,
  input wire logic tach_output_o,
  input wire logic tach_output_oe
);
  // ----
  // Checks
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_ov; overvoltage_threshold [*5]; endsequence
  sequence s_off; !coil_out_a && !coil_out_b; endsequence
  a_ov_coils_off: assert property (s_ov |=> s_off)
    else $error("coil driven in overvoltage");
  a_ov_tach_off: assert property (s_ov |=> !tach_output_oe)
    else $error("tach held in overvoltage");
  a_pwm_gate_off: assert property (!pwm_in [*5] |=> s_off)
    else $error("coil driven while pwm low");
  a_coil_rise_cause: assert property ($rose(coil_out_a) |-> $past(pwm_in, 2))
    else $error("coil rose without pwm");
  a_tach_data_low: assert property (tach_output_o == 1'b0)
    else $error("tach data not low");
  a_no_both_high: assert property (!(coil_out_a && coil_out_b))
    else $error("both coils high");
  a_settle_quiet: assert property (s_ov ##1 !overvoltage_threshold [*3] |=> s_off)
    else $error("coil driven while settling");
  a_reset_idle: assert property ($rose(rst_n) |-> s_off and !tach_output_oe)
    else $error("outputs active after reset");
endmodule // scf_fan_monitor

bind scf_fan_ctrl scf_fan_monitor i_scf_fan_monitor (.clk(clk), .rst_n(rst_n),
  .pole_south(pole_south), .pwm_in(pwm_in), .overvoltage_threshold(overvoltage_threshold),
  .coil_out_a(coil_out_a), .coil_out_b(coil_out_b), .tach_output_o(tach_output_o),
  .tach_output_oe(tach_output_oe));

// ==== verification/scf_host_pwm.sv ====
`timescale 1ns/10ps
module scf_host_pwm #(
  parameter int unsigned PERIOD = 2000
) (
  input wire logic clk,
  input wire logic en,
  input wire logic chop,
  output logic pwm
);
  int unsigned cnt = 0;
  initial pwm = 1'b0;
  // Default period of 2000 cycles gives 25 kHz, inside the legal band
  always @(negedge clk) begin
    cnt <= (cnt + 1) % PERIOD;
    pwm <= en && (!chop || cnt < PERIOD / 2); // Held high while chop is low, for supply speed control
  end
endmodule // scf_host_pwm

// ==== verification/scf_fan_ctrl_test.sv ====
`timescale 1ns/10ps
module scf_fan_ctrl_test;
  logic clk = 1'b0, rst_n = 1'b0, pole_south = 1'b1, ov = 1'b0, en = 1'b0, chop = 1'b0;
  logic pwm, a, b, tq, oe;
  int n_errors = 0, tests_run = 0;
  always #10 clk = ~clk;
  scf_host_pwm i_scf_host_pwm (.clk(clk), .en(en), .chop(chop), .pwm(pwm));
  scf_fan_ctrl i_scf_fan_ctrl (.clk(clk), .rst_n(rst_n), .pole_south(pole_south), .pwm_in(pwm),
    .overvoltage_threshold(ov), .coil_out_a(a), .coil_out_b(b), .tach_output_o(tq),
    .tach_output_oe(oe));
  // ----
  // Helpers
  // ----
  task automatic chk(input logic [2:0] got, input logic [2:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic in_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    tests_run++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Ramp and chop are judged by counting high cycles, not by one sample
  task automatic count_hi(input int n, input logic use_b, output logic [31:0] c);
    c = 32'h0;
    repeat (n) begin
      @(negedge clk);
      c = c + 32'((use_b ? b : a) === 1'b1);
    end
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_start;
    chk({a, b, oe}, 3'h0);
    en = 1'b1;
    wait_n(4900);
    chk({1'b0, a, b}, 3'h0);
    wait_n(10300);
    chk({tq, a, b}, 3'h2);
  endtask
  task automatic t_turn(input logic south);
    logic [31:0] c;
    logic t0;
    t0 = oe;
    pole_south = south;
    count_hi(10300, south, c);
    in_rng(c, 32'd100, 32'd10290);
    chk({oe, a, b}, {~t0, south, ~south});
  endtask
  task automatic t_chop;
    logic [31:0] c;
    chop = 1'b1;
    wait_n(2000);
    count_hi(4000, 1'b0, c);
    in_rng(c, 32'd1996, 32'd2004);
    chop = 1'b0;
  endtask
  task automatic t_ov;
    ov = 1'b1;
    wait_n(10);
    chk({oe, a, b}, 3'h0);
    ov = 1'b0;
    wait_n(4900);
    chk({1'b0, a, b}, 3'h0);
    wait_n(10300);
    chk({1'b0, a, b}, 3'h2);
  endtask
  task automatic wrap_up;
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    wait_n(2);
    rst_n = 1'b1;
    t_start;
    t_turn(1'b0);
    t_turn(1'b1);
    t_chop;
    t_ov;
    wrap_up;
  end
  initial begin
    #1500000;
    n_errors++;
    wrap_up;
  end
endmodule // scf_fan_ctrl_test
